/* rtl/sirp_pkg.sv */
package sirp_pkg;
  // seven fixed address bits, msb first, then the direction bit
  localparam logic [6:0] SIRP_DEV_ID = 7'h57;
  localparam logic SIRP_DIR_WR = 1'b0;
  localparam logic SIRP_DIR_RD = 1'b1;
  localparam logic [7:0] SIRP_ADDR_WR = {SIRP_DEV_ID, SIRP_DIR_WR};
  localparam logic [7:0] SIRP_ADDR_RD = {SIRP_DEV_ID, SIRP_DIR_RD};
  localparam logic [7:0] SIRP_FIFO_PTR_DEF = 8'h10;
  localparam logic [7:0] SIRP_PTR_STEP = 8'h01;
  localparam int SIRP_MSB = 7;
  localparam logic [3:0] SIRP_BIT_LAST = 4'h7;
  localparam logic [3:0] SIRP_BIT_ACK = 4'h8;
  localparam logic [3:0] SIRP_BIT_STEP = 4'h1;
  localparam logic [1:0] SIRP_Q0 = 2'h0;
  localparam logic [1:0] SIRP_Q1 = 2'h1;
  localparam logic [1:0] SIRP_Q2 = 2'h2;
  localparam logic [1:0] SIRP_Q3 = 2'h3;
  localparam longint SIRP_CLK_HZ = 125000000;
  localparam longint SIRP_SCL_MAX_HZ = 400000;
  // quarter of the fastest allowed link period, rounded up so the rate never exceeds it
  localparam int SIRP_QTR_CYC = int'((SIRP_CLK_HZ + 4 * SIRP_SCL_MAX_HZ - 1) / (4 * SIRP_SCL_MAX_HZ));
  localparam int SIRP_RETRY_DEF = 3;

  typedef enum logic [2:0] {
    SIRP_D_IDLE = 3'b000,
    SIRP_D_ADDR = 3'b001,
    SIRP_D_PTR = 3'b010,
    SIRP_D_WR = 3'b011,
    SIRP_D_RD = 3'b100
  } sirp_dst_e;

  typedef enum logic [2:0] {
    SIRP_H_IDLE = 3'b000,
    SIRP_H_START = 3'b001,
    SIRP_H_BIT = 3'b010,
    SIRP_H_RSTART = 3'b011,
    SIRP_H_STOP = 3'b100
  } sirp_hst_e;

  typedef enum logic [2:0] {
    SIRP_R_AW = 3'b000,
    SIRP_R_PTR = 3'b001,
    SIRP_R_WD = 3'b010,
    SIRP_R_AR = 3'b011,
    SIRP_R_RD = 3'b100
  } sirp_role_e;
endpackage : sirp_pkg

/* rtl/sirp_if.sv */
`timescale 1ns/1ps
interface sirp_if;
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // open-drain wires with pullups: any enabled low driver wins
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);

  modport host (
    output scl_o,
    output scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input scl,
    input sda
  );

  modport dev (
    output d_sda_o,
    output d_sda_oe,
    input scl,
    input sda
  );
endinterface : sirp_if

/* rtl/sirp_evt_sync.sv */
`timescale 1ns/1ps
module sirp_evt_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic tgl,
  input wire logic [W-1:0] dat_in,
  output logic stb,
  output logic [W-1:0] dat
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stb;
    logic [W-1:0] dat;
  } sirp_esync_s;

  sirp_esync_s q;
  sirp_esync_s d;

  // dat_in is held by the sender for a whole link byte after the toggle,
  // so it is stable by the time the synchronised toggle is seen
  always_comb begin
    d = q;
    if (clk_en) begin
      d.s1 = tgl;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.stb = q.s2 ^ q.s3;
      if (q.s2 ^ q.s3) begin
        d.dat = dat_in;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign stb = q.stb;
  assign dat = q.dat;
endmodule : sirp_evt_sync

/* rtl/sirp_dev_end.sv */
`timescale 1ns/1ps
module sirp_dev_end
  import sirp_pkg::*;
#(
  parameter logic [7:0] FIFO_PTR = SIRP_FIFO_PTR_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  sirp_if.dev lnk,
  output logic [7:0] fetch_ptr,
  input wire logic [7:0] rd_byte,
  output logic wr_stb,
  output logic [7:0] wr_ptr,
  output logic [7:0] wr_byte,
  output logic rd_stb,
  output logic [7:0] rd_ptr
);
  typedef struct packed {
    sirp_dst_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic first;
    logic oe;
    logic start_seen;
    logic stop_seen;
    logic wr_tgl;
    logic [15:0] wr_pair;
    logic rd_tgl;
    logic [7:0] rd_at;
  } sirp_dlnk_s;

  sirp_dlnk_s q;
  sirp_dlnk_s d;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic [7:0] nxt;
  logic [7:0] adv;
  logic exp_bit;

  // start and stop are the only events with scl high, so they are caught on
  // the data line's own edges and turned into toggles
  // start detect
  always_ff @(negedge lnk.sda or posedge sys_rst) begin
    if (sys_rst) begin
      start_tgl_q <= 1'b0;
    end else if (lnk.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(posedge lnk.sda or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tgl_q <= 1'b0;
    end else if (lnk.scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // the link side runs on the falling scl edge: the bit of the ending high
  // pulse is sampled and the next bit (or ack) is driven for the low phase.
  // the toggles only change while scl is high, so they are settled here.
  always_comb begin
    d = q;
    nxt = {q.sh[SIRP_MSB-1:0], lnk.sda};
    adv = (q.ptr == FIFO_PTR) ? q.ptr : q.ptr + SIRP_PTR_STEP;
    exp_bit = SIRP_ADDR_WR[3'(SIRP_MSB - int'(q.cnt))];
    d.start_seen = start_tgl_q;
    d.stop_seen = stop_tgl_q;
    if (start_tgl_q != q.start_seen) begin
      // a stop in the same high pulse as a start is not honoured
      d.st = SIRP_D_ADDR;
      d.cnt = '0;
      d.oe = 1'b0;
    end else if (stop_tgl_q != q.stop_seen) begin
      d.st = SIRP_D_IDLE;
      d.oe = 1'b0;
    end else if (q.st == SIRP_D_RD) begin
      if (q.cnt == SIRP_BIT_ACK) begin
        d.cnt = '0;
        if (q.first || !lnk.sda) begin
          d.first = 1'b0;
          d.sh = rd_byte;
          d.oe = !rd_byte[SIRP_MSB];
          d.ptr = adv;
          d.rd_tgl = !q.rd_tgl;
          d.rd_at = q.ptr;
        end else begin
          // not acknowledged: release and wait for the stop
          d.st = SIRP_D_IDLE;
          d.oe = 1'b0;
        end
      end else begin
        d.cnt = q.cnt + SIRP_BIT_STEP;
        if (q.cnt == SIRP_BIT_LAST) begin
          d.oe = 1'b0;
        end else begin
          d.sh = {q.sh[SIRP_MSB-1:0], 1'b0};
          d.oe = !q.sh[SIRP_MSB-1];
        end
      end
    end else if (q.st != SIRP_D_IDLE) begin
      if (q.cnt == SIRP_BIT_ACK) begin
        d.cnt = '0;
        d.oe = 1'b0;
      end else begin
        d.sh = nxt;
        d.cnt = q.cnt + SIRP_BIT_STEP;
        if (q.st == SIRP_D_ADDR && q.cnt != SIRP_BIT_LAST && lnk.sda != exp_bit) begin
          d.st = SIRP_D_IDLE;
        end else if (q.cnt == SIRP_BIT_LAST) begin
          d.oe = 1'b1;
          case (q.st)
            SIRP_D_ADDR: begin
              if (nxt[0] == SIRP_DIR_RD) begin
                d.st = SIRP_D_RD;
                d.first = 1'b1;
              end else begin
                d.st = SIRP_D_PTR;
              end
            end
            SIRP_D_PTR: begin
              d.ptr = nxt;
              d.st = SIRP_D_WR;
            end
            SIRP_D_WR: begin
              d.wr_pair = {q.ptr, nxt};
              d.wr_tgl = !q.wr_tgl;
              d.ptr = q.ptr + SIRP_PTR_STEP;
            end
            default: begin
              d.st = SIRP_D_IDLE;
              d.oe = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(negedge lnk.scl or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.d_sda_o = 1'b0;
  assign lnk.d_sda_oe = q.oe;
  // quasi-static: changes only at a pointer load, a written byte or a byte fetch, a full byte ahead of its use
  assign fetch_ptr = q.ptr;

  sirp_evt_sync #(
    .W(16)
  ) u_wr_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .tgl(q.wr_tgl),
    .dat_in(q.wr_pair),
    .stb(wr_stb),
    .dat({wr_ptr, wr_byte})
  );

  sirp_evt_sync #(
    .W(8)
  ) u_rd_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .tgl(q.rd_tgl),
    .dat_in(q.rd_at),
    .stb(rd_stb),
    .dat(rd_ptr)
  );
endmodule : sirp_dev_end

/* rtl/sirp_host_end.sv */
`timescale 1ns/1ps
module sirp_host_end
  import sirp_pkg::*;
#(
  parameter int QTR_CYC = SIRP_QTR_CYC,
  parameter int RETRY = SIRP_RETRY_DEF,
  parameter int LEN_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  sirp_if.host lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_ptr,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic fail
);
  localparam int DIV_W = $clog2(QTR_CYC + 1);
  localparam int TRY_W = $clog2(RETRY + 2);
  localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

  typedef struct packed {
    sirp_hst_e st;
    sirp_role_e role;
    logic [1:0] qt;
    logic [DIV_W-1:0] div;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rd;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] left;
    logic [TRY_W-1:0] tries;
    logic again;
    logic err;
    logic s1;
    logic s2;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic take;
    logic [7:0] rdat;
    logic rval;
    logic done;
    logic fail;
  } sirp_host_s;

  sirp_host_s q;
  sirp_host_s d;
  logic tick;

  // quarter-period sequencer: q0 scl low, q1 set sda, q2 scl high, q3 sample
  always_comb begin
    d = q;
    tick = 1'b0;
    if (clk_en) begin
      d.take = 1'b0;
      d.rval = 1'b0;
      d.done = 1'b0;
      d.fail = 1'b0;
      d.s1 = lnk.sda;
      d.s2 = q.s1;
      tick = q.div == DIV_W'(QTR_CYC - 1);
      d.div = tick ? '0 : q.div + DIV_W'(1);
      if (q.st == SIRP_H_IDLE) begin
        d.div = '0;
        d.ready = 1'b1;
        if (cmd_valid) begin
          d.ready = 1'b0;
          d.rd = cmd_read;
          d.ptr = cmd_ptr;
          d.len = cmd_len;
          d.tries = '0;
          d.err = 1'b0;
          d.st = SIRP_H_START;
          d.qt = SIRP_Q0;
        end
      end else if (tick) begin
        d.qt = q.qt + 2'h1;
        case (q.st)
          SIRP_H_START: begin
            d.sda_oe = 1'b1;
            d.st = SIRP_H_BIT;
            d.qt = SIRP_Q0;
            d.role = SIRP_R_AW;
            d.sh = SIRP_ADDR_WR;
            d.cnt = '0;
            d.left = q.len;
            d.again = 1'b0;
          end
          SIRP_H_RSTART: begin
            case (q.qt)
              SIRP_Q0: d.scl_oe = 1'b1;
              SIRP_Q1: d.sda_oe = 1'b0;
              SIRP_Q2: d.scl_oe = 1'b0;
              default: begin
                d.sda_oe = 1'b1;
                d.st = SIRP_H_BIT;
                d.role = SIRP_R_AR;
                d.sh = SIRP_ADDR_RD;
                d.cnt = '0;
              end
            endcase
          end
          SIRP_H_STOP: begin
            case (q.qt)
              SIRP_Q0: d.scl_oe = 1'b1;
              SIRP_Q1: d.sda_oe = 1'b1;
              SIRP_Q2: d.scl_oe = 1'b0;
              default: begin
                d.sda_oe = 1'b0;
                d.st = q.again ? SIRP_H_START : SIRP_H_IDLE;
                d.done = !q.again && !q.err;
                d.fail = !q.again && q.err;
              end
            endcase
          end
          SIRP_H_BIT: begin
            case (q.qt)
              SIRP_Q0: d.scl_oe = 1'b1;
              SIRP_Q1: begin
                if (q.cnt == SIRP_BIT_ACK) begin
                  // ack all but last read byte
                  d.sda_oe = q.role == SIRP_R_RD && q.left != LEN_ONE;
                end else begin
                  d.sda_oe = q.role != SIRP_R_RD && !q.sh[SIRP_MSB];
                end
              end
              SIRP_Q2: d.scl_oe = 1'b0;
              default: begin
                d.sh = {q.sh[SIRP_MSB-1:0], q.s2};
                d.cnt = q.cnt + SIRP_BIT_STEP;
                if (q.cnt == SIRP_BIT_LAST && q.role == SIRP_R_RD) begin
                  d.rdat = {q.sh[SIRP_MSB-1:0], q.s2};
                  d.rval = 1'b1;
                end
                if (q.cnt == SIRP_BIT_ACK) begin
                  d.cnt = '0;
                  if (q.role == SIRP_R_RD) begin
                    if (q.left == LEN_ONE) begin
                      d.st = SIRP_H_STOP;
                    end else begin
                      d.left = q.left - LEN_ONE;
                    end
                  end else if (q.s2) begin
                    d.st = SIRP_H_STOP;
                    if (int'(q.tries) < RETRY && q.role != SIRP_R_WD) begin
                      d.tries = q.tries + TRY_W'(1);
                      d.again = 1'b1;
                    end else begin
                      d.err = 1'b1;
                    end
                  end else begin
                    case (q.role)
                      SIRP_R_AW: begin
                        d.role = SIRP_R_PTR;
                        d.sh = q.ptr;
                      end
                      SIRP_R_PTR: begin
                        if (q.rd) begin
                          d.st = SIRP_H_RSTART;
                        end else begin
                          d.role = SIRP_R_WD;
                          d.sh = wr_data;
                          d.take = 1'b1;
                        end
                      end
                      SIRP_R_WD: begin
                        if (q.left == LEN_ONE) begin
                          d.st = SIRP_H_STOP;
                        end else begin
                          d.left = q.left - LEN_ONE;
                          d.sh = wr_data;
                          d.take = 1'b1;
                        end
                      end
                      default: d.role = SIRP_R_RD;
                    endcase
                  end
                end
              end
            endcase
          end
          default: d.st = SIRP_H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lnk.scl_o = 1'b0;
  assign lnk.scl_oe = q.scl_oe;
  assign lnk.m_sda_o = 1'b0;
  assign lnk.m_sda_oe = q.sda_oe;
  assign cmd_ready = q.ready;
  assign wr_take = q.take;
  assign rd_data = q.rdat;
  assign rd_valid = q.rval;
  assign done = q.done;
  assign fail = q.fail;
endmodule : sirp_host_end

/* verif/sirp_link_asserts.sv */
`timescale 1ns/1ps
module sirp_link_asserts
  import sirp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe
);
  logic scl_q, sda_q, rdm_q, later_q;
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic sclr, start, stop;
  assign sclr = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  // bit position rebuilt from the wires, so both ends are judged by the bus alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rdm_q <= 1'b0;
      later_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 7'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt_q <= 4'h0;
        rdm_q <= 1'b0;
        later_q <= 1'b0;
      end else if (sclr) begin
        sh_q <= {sh_q[5:0], sda};
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q == 4'h7 && !later_q) rdm_q <= sda;
        if (cnt_q == 4'h8) later_q <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // repeat counts assume the bench's quarter period of 4 clocks
  chk_ack_ninth: assert property (
    sclr && cnt_q == 4'h8 && (!rdm_q || !later_q) |-> d_sda_oe [*5])
    else $error("acknowledge not held through ninth pulse");
  chk_rd_dev_free: assert property (
    sclr && cnt_q == 4'h8 && rdm_q && later_q |-> !d_sda_oe)
    else $error("device drives during master acknowledge");
  chk_nack_stop: assert property (
    sclr && cnt_q == 4'h8 && rdm_q && later_q && !m_sda_oe |-> ##[1:60] stop)
    else $error("no stop after not-acknowledge");
  chk_wr_dev_quiet: assert property (
    sclr && cnt_q < 4'h8 && !rdm_q |-> !d_sda_oe)
    else $error("device drives during a written bit");
  chk_addr_bits: assert property (
    sclr && cnt_q == 4'h7 && !later_q |-> sh_q == SIRP_DEV_ID)
    else $error("address bits wrong");
  chk_dev_hold_hi: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device data moved while clock high");
  chk_host_hold_hi: assert property (
    scl && $past(scl) && !start && !stop |-> $stable(m_sda_oe))
    else $error("host data moved while clock high");
  chk_stop_free: assert property (
    stop |=> (!d_sda_oe && !m_sda_oe) [*6])
    else $error("line driven after stop");
endmodule : sirp_link_asserts

/* verif/sirp_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module sirp_bench
  import sirp_pkg::*;
;
  logic clk = 1'b0;
  logic qclk = 1'b0;
  logic sys_rst = 1'b0;
  logic en = 1'b1;
  logic cmd_valid = 1'b0;
  logic c2_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];
  logic [7:0] bank [0:255];
  logic [7:0] fifo_v = 8'h00;
  logic [2:0] widx = 3'h0;
  logic [2:0] ridx = 3'h0;
  logic cmd_ready, wr_take, rd_valid, done, fail, c2_ready, c2_done, c2_fail;
  logic wr_stb, rd_stb;
  logic [7:0] rd_data, fetch_ptr, rd_byte, wr_ptr, wr_byte, rd_ptr, wr_data;
  int bad_count = 0;
  int tests_run = 0;
  int starts2 = 0;
  sirp_if lnk ();
  sirp_if lnk2 ();
  sirp_if lnk3 ();
  always #4 clk = ~clk;
  // quarter-bit clock of the third bus, same 8 ns period as clk, rising 3 ns after it
  initial begin
    #3;
    forever #4 qclk = ~qclk;
  end
  sirp_host_end #(.QTR_CYC(4), .RETRY(2)) u_sirp_host_end (.clk, .sys_rst, .clk_en(en),
    .lnk(lnk.host), .cmd_valid, .cmd_ready, .cmd_read, .cmd_ptr, .cmd_len, .wr_data,
    .wr_take, .rd_data, .rd_valid, .done, .fail);
  // no device on this bus: every address goes unanswered
  sirp_host_end #(.QTR_CYC(4), .RETRY(2)) u_sirp_host_end_2 (.clk, .sys_rst, .clk_en(en),
    .lnk(lnk2.host), .cmd_valid(c2_valid), .cmd_ready(c2_ready), .cmd_read, .cmd_ptr,
    .cmd_len, .wr_data, .wr_take(), .rd_data(), .rd_valid(), .done(c2_done), .fail(c2_fail));
  sirp_dev_end u_sirp_dev_end (.clk, .sys_rst, .clk_en(en), .lnk(lnk.dev), .fetch_ptr,
    .rd_byte, .wr_stb, .wr_ptr, .wr_byte, .rd_stb, .rd_ptr);
  sirp_dev_end u_sirp_dev_end_2 (.clk, .sys_rst, .clk_en(en), .lnk(lnk3.dev), .fetch_ptr(),
    .rd_byte, .wr_stb(), .wr_ptr(), .wr_byte(), .rd_stb(), .rd_ptr());
  sirp_link_asserts u_sirp_link_asserts (.clk, .sys_rst, .scl(lnk.scl), .sda(lnk.sda),
    .m_sda_oe(lnk.m_sda_oe), .d_sda_oe(lnk.d_sda_oe));
  assign wr_data = wbuf[widx];
  assign rd_byte = (fetch_ptr == SIRP_FIFO_PTR_DEF) ? fifo_v : bank[fetch_ptr];
  always @(posedge clk) begin
    if (wr_stb) bank[wr_ptr] <= wr_byte;
    if (rd_stb && rd_ptr == SIRP_FIFO_PTR_DEF) fifo_v <= fifo_v + 8'h01;
    if (wr_take) widx <= widx + 3'h1;
    if (rd_valid) begin
      rbuf[ridx] <= rd_data;
      ridx <= ridx + 3'h1;
    end
  end
  always @(negedge lnk2.sda) if (lnk2.scl === 1'b1) starts2++;
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic run_cmd(input logic rd, input logic [7:0] p, input logic [7:0] n,
      output logic ok);
    int k;
    @(negedge clk);
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_ptr <= p;
    cmd_len <= n;
    widx <= 3'h0;
    ridx <= 3'h0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (k = 0; k < 5000 && done !== 1'b1 && fail !== 1'b1; k++) @(negedge clk);
    ok = (done === 1'b1);
  endtask : run_cmd
  // bench-made link on the third bus: 32 ns clock period, four qclk edges per bit
  task automatic bb(input logic s, input logic c);
    @(posedge qclk);
    lnk3.m_sda_oe <= s;
    lnk3.scl_oe <= c;
  endtask : bb
  task automatic bb_start;
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
  endtask : bb_start
  task automatic bb_byte(input logic [7:0] v, output logic ak);
    int i;
    for (i = 7; i >= 0; i--) begin
      bb(!v[i], 1'b1);
      bb(!v[i], 1'b0);
      bb(!v[i], 1'b0);
      bb(!v[i], 1'b1);
    end
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    bb(1'b0, 1'b0);
    ak = lnk3.d_sda_oe;
    bb(1'b0, 1'b1);
  endtask : bb_byte
  task automatic t_retry;
    int k;
    @(posedge clk);
    c2_valid <= 1'b1;
    @(posedge clk);
    c2_valid <= 1'b0;
    for (k = 0; k < 5000 && c2_fail !== 1'b1 && c2_done !== 1'b1; k++) @(negedge clk);
    `CHK("gave up", 1'b1, c2_fail);
    `CHK("attempts", 3, starts2);
    $display("retry test ends");
  endtask : t_retry
  task automatic t_write;
    logic ok;
    int i;
    for (i = 0; i < 4; i++) wbuf[i] = 8'(8'h11 * (i + 1));
    run_cmd(1'b0, 8'h20, 8'h04, ok);
    `CHK("write done", 1'b1, ok);
    for (i = 0; i < 4; i++) `CHK("bank", 8'(8'h11 * (i + 1)), bank[8'h20 + i]);
    $display("write test ends");
  endtask : t_write
  task automatic t_read;
    logic ok;
    int i;
    run_cmd(1'b1, 8'h20, 8'h04, ok);
    `CHK("read done", 1'b1, ok);
    `CHK("read count", 3'h4, ridx);
    for (i = 0; i < 4; i++) `CHK("read", 8'(8'h11 * (i + 1)), rbuf[i]);
    $display("read test ends");
  endtask : t_read
  task automatic t_wrap;
    logic ok;
    wbuf[0] = 8'h55;
    wbuf[1] = 8'h66;
    run_cmd(1'b0, 8'hff, 8'h02, ok);
    `CHK("wrap write done", 1'b1, ok);
    `CHK("wrap top", 8'h55, bank[255]);
    `CHK("wrap low", 8'h66, bank[0]);
    run_cmd(1'b1, 8'hff, 8'h03, ok);
    `CHK("wrap read done", 1'b1, ok);
    `CHK("wrap rd0", 8'h55, rbuf[0]);
    `CHK("wrap rd1", 8'h66, rbuf[1]);
    `CHK("wrap rd2", 8'h3d, rbuf[2]);
    $display("wrap test ends");
  endtask : t_wrap
  task automatic t_fifo;
    logic ok;
    logic [7:0] f;
    int i;
    f = fifo_v;
    run_cmd(1'b1, 8'h0e, 8'h05, ok);
    `CHK("fifo read done", 1'b1, ok);
    `CHK("pre window", 8'h33, rbuf[1]);
    for (i = 2; i < 5; i++) `CHK("window", 8'(f + i - 2), rbuf[i]);
    run_cmd(1'b1, 8'h11, 8'h01, ok);
    `CHK("reload done", 1'b1, ok);
    `CHK("past window", 8'h2d, rbuf[0]);
    $display("fifo test ends");
  endtask : t_fifo
  task automatic t_badaddr;
    logic ak;
    bb_start;
    bb_byte(8'hee, ak);
    `CHK("foreign ack", 1'b0, ak);
    bb_byte(SIRP_ADDR_WR, ak);
    `CHK("stays out", 1'b0, ak);
    bb_start;
    bb_byte(SIRP_ADDR_WR, ak);
    `CHK("own ack", 1'b1, ak);
    bb_byte(8'h30, ak);
    `CHK("pointer ack", 1'b1, ak);
    bb(1'b1, 1'b1);
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    // msb high keeps sda still at the first clock fall, so no false start
    bb_byte(SIRP_ADDR_WR, ak);
    `CHK("after stop", 1'b0, ak);
    $display("address test ends");
  endtask : t_badaddr
  initial begin
    int i;
    // a real rising edge, so the scl-clocked link side resets as well
    sys_rst <= 1'b1;
    for (i = 0; i < 256; i++) bank[i] = 8'(i) ^ 8'h3c;
    lnk2.d_sda_o = 1'b0;
    lnk2.d_sda_oe = 1'b0;
    lnk3.scl_o = 1'b0;
    lnk3.scl_oe = 1'b0;
    lnk3.m_sda_o = 1'b0;
    lnk3.m_sda_oe = 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_retry;
    t_write;
    t_wrap;
    t_read;
    t_fifo;
    t_badaddr;
    conclude();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : sirp_bench
